// ==== core/ssom_compare_out.sv ====
// compare output shaper: toggles or emits a pulse of set width per event
// assumes compare_event is a one-cycle pulse from logic on pclk
module ssom_compare_out
   import ssom_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic compare_event, // position compare satisfied, pulse
   input wire ssom_cmode_t mode, // toggle or pulse
   input wire logic [15:0] width, // pulse width in cycles, 0 acts as 1
   output logic level // shaped compare level
);

   ssom_cstate_t state_r;
   logic [15:0] cnt_r;
   logic level_r;

   // ==========================================================
   // shaper
   // [RL7] toggle or pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= CS_IDLE;
         cnt_r <= 16'h0000;
         level_r <= 1'b0;
      end else if (compare_event && mode == CM_TOGGLE) begin
         state_r <= CS_IDLE;
         cnt_r <= 16'h0000;
         level_r <= ~level_r;
      end else if (compare_event) begin
         state_r <= CS_PULSE;
         cnt_r <= (width == 16'h0000) ? 16'h0000 : width - 16'h0001;
         level_r <= 1'b1;
      end else begin
         unique case (state_r)
            CS_IDLE: begin
               cnt_r <= 16'h0000;
            end
            CS_PULSE: begin
               if (cnt_r == 16'h0000) begin
                  state_r <= CS_IDLE;
                  level_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r - 16'h0001;
               end
            end
         endcase
      end
   end

   assign level = level_r;

   // ==========================================================
   // checks
   a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
      compare_event && mode == CM_TOGGLE |=> level != $past(level))
      else $error("compare toggle did not flip");

   a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
      compare_event && mode == CM_PULSE && width == 16'h0003 ##1 !compare_event [*4]
      |-> $past(level, 3) && $past(level, 2) && $past(level) && !level)
      else $error("compare pulse width wrong");

endmodule

// ==== core/ssom_pkg.sv ====
// constants, types and register map of the servo status output mux
// assumes one clock domain; registers reached over a 32-bit apb slave
package ssom_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] SSOM_OFS_SEL = 8'h00;
   localparam logic [7:0] SSOM_OFS_RANGE = 8'h04;
   localparam logic [7:0] SSOM_OFS_CCFG = 8'h08;
   localparam logic [7:0] SSOM_OFS_COND = 8'h0C;
   localparam logic [7:0] SSOM_OFS_PINS = 8'h10;
   localparam logic [7:0] SSOM_OFS_ISTAT = 8'h14;
   localparam logic [7:0] SSOM_OFS_IMASK = 8'h18;

   // ==========================================================
   // field layout
   localparam int unsigned SSOM_NPINS = 3;
   localparam int unsigned SSOM_SEL_W = 4;
   localparam int unsigned SSOM_RANGE_W = 16;
   localparam int unsigned SSOM_CCFG_MODE_BIT = 0;
   localparam int unsigned SSOM_CCFG_WIDTH_LSB = 16;
   localparam int unsigned SSOM_WIDTH_W = 16;
   localparam int unsigned SSOM_NCOND = 9;
   localparam int unsigned SSOM_NEV = 5;
   localparam int unsigned SSOM_EV_ALARM = 0;
   localparam int unsigned SSOM_EV_INPOS = 1;
   localparam int unsigned SSOM_EV_COMPARE = 2;
   localparam int unsigned SSOM_EV_POSLIM = 3;
   localparam int unsigned SSOM_EV_NEGLIM = 4;

   // ==========================================================
   // output functions
   typedef enum logic [3:0] {
      FN_OFF = 4'h0,
      FN_ALARM = 4'h1,
      FN_READY = 4'h2,
      FN_IN_POSITION = 4'h3,
      FN_BRAKE = 4'h4,
      FN_ZERO_SPEED = 4'h5,
      FN_SERVO_ON = 4'h6,
      FN_POS_LIMIT = 4'h7,
      FN_NEG_LIMIT = 4'h8,
      FN_COMPARE = 4'h9
   } ssom_fn_t;

   typedef enum logic {
      CM_TOGGLE = 1'b0,
      CM_PULSE = 1'b1
   } ssom_cmode_t;

   typedef enum logic {
      CS_IDLE = 1'b0,
      CS_PULSE = 1'b1
   } ssom_cstate_t;

   // internal status conditions, one bit per function
   typedef struct packed {
      logic compare_match_out;
      logic neg_limit_echo_out;
      logic pos_limit_echo_out;
      logic servo_enabled_out;
      logic zero_speed_out;
      logic brake_release_out;
      logic in_position_out;
      logic ready_out;
      logic alarm_out;
   } ssom_cond_t;

   // ==========================================================
   // reset values
   localparam ssom_fn_t SSOM_SEL1_RST = FN_BRAKE;
   localparam ssom_fn_t SSOM_SEL2_RST = FN_READY;
   localparam ssom_fn_t SSOM_SEL3_RST = FN_ALARM;
   localparam logic [15:0] SSOM_RANGE_RST = 16'h000A;
   localparam logic [15:0] SSOM_WIDTH_RST = 16'h0010;
   localparam ssom_cmode_t SSOM_CMODE_RST = CM_TOGGLE;
   localparam logic [4:0] SSOM_IMASK_RST = 5'h00;

endpackage

// ==== core/ssom_top.sv ====
// servo status output mux: routes drive conditions to three output pins
// assumes condition inputs come from pclk logic; limit inputs come from pins
//
// Contract
// [RL1] fault output high whenever a drive alarm is present; default on pin 3
// [RL2] ready output high once servo is powered; default on pin 2
// [RL3] in-position high when move done and position error within range
// [RL4] zero-speed output high while zero-speed clamp is active
// [RL5] servo-enabled output high while servo enabled, separate from ready
// [RL6] limit echo outputs follow the positive and negative limit inputs
// [RL7] compare output toggles or pulses for set width on compare match
// [RL8] pin 1 carries brake release function by default
// [RL9] one function may drive several pins at once
// [RL10] each pin has its own selector, applied every cycle
module ssom_top
   import ssom_pkg::*;
(
   input wire logic pclk, // system clock, 250 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped or unaligned
   input wire logic drive_alarm, // drive alarm present
   input wire logic servo_powered, // servo powered on
   input wire logic servo_enabled, // servo enabled
   input wire logic move_done, // positioning move finished
   input wire logic [31:0] pos_error, // signed position error
   input wire logic zero_clamp_active, // zero-speed clamp active
   input wire logic brake_release, // external brake release request
   input wire logic pos_limit_in, // positive limit, from pin
   input wire logic neg_limit_in, // negative limit, from pin
   input wire logic compare_event, // position compare satisfied, pulse
   output logic output_pin_1, // digital output 1
   output logic output_pin_2, // digital output 2
   output logic output_pin_3, // digital output 3
   output logic irq // level interrupt
);

   // ==========================================================
   // declarations
   ssom_fn_t sel_r [SSOM_NPINS];
   logic [15:0] range_r;
   logic [15:0] width_r;
   ssom_cmode_t cmode_r;
   logic [4:0] istat_r;
   logic [4:0] istat_nxt;
   logic [4:0] imask_r;
   logic [SSOM_NPINS-1:0] pin_r;
   logic irq_r;
   logic [31:0] prdata_r;
   logic [31:0] rdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic map_hit;
   logic setup_ph;
   logic wr_en;
   logic pos_sync1_r;
   logic pos_sync2_r;
   logic neg_sync1_r;
   logic neg_sync2_r;
   logic [31:0] err_abs;
   logic compare_level;
   ssom_cond_t cond;
   ssom_cond_t cond_d_r;
   logic [4:0] ev;

   // ==========================================================
   // apb decode
   assign setup_ph = psel && !penable;
   assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;

   always_comb begin
      map_hit = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (paddr[1:0] != 2'h0) begin
         map_hit = 1'b0;
      end else begin
         unique case (paddr)
            SSOM_OFS_SEL: begin
               rdata_nxt[11:0] = {sel_r[2], sel_r[1], sel_r[0]};
            end
            SSOM_OFS_RANGE: begin
               rdata_nxt[15:0] = range_r;
            end
            SSOM_OFS_CCFG: begin
               rdata_nxt[SSOM_CCFG_MODE_BIT] = cmode_r;
               rdata_nxt[SSOM_CCFG_WIDTH_LSB +: SSOM_WIDTH_W] = width_r;
            end
            SSOM_OFS_COND: begin
               rdata_nxt[SSOM_NCOND-1:0] = cond;
            end
            SSOM_OFS_PINS: begin
               rdata_nxt[SSOM_NPINS-1:0] = pin_r;
            end
            SSOM_OFS_ISTAT: begin
               rdata_nxt[SSOM_NEV-1:0] = istat_r;
            end
            SSOM_OFS_IMASK: begin
               rdata_nxt[SSOM_NEV-1:0] = imask_r;
            end
            default: begin
               map_hit = 1'b0;
            end
         endcase
      end
   end

   // ready rises in the first access cycle: no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph) begin
         pready_r <= 1'b1;
         pslverr_r <= !map_hit;
         prdata_r <= (map_hit && !pwrite) ? rdata_nxt : 32'h0000_0000;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // ==========================================================
   // configuration registers
   // [RL8] pin 1 defaults to brake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_r[0] <= SSOM_SEL1_RST;
         sel_r[1] <= SSOM_SEL2_RST;
         sel_r[2] <= SSOM_SEL3_RST;
      end else if (wr_en && paddr == SSOM_OFS_SEL) begin
         sel_r[0] <= ssom_fn_t'(pwdata[3:0]);
         sel_r[1] <= ssom_fn_t'(pwdata[7:4]);
         sel_r[2] <= ssom_fn_t'(pwdata[11:8]);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         range_r <= SSOM_RANGE_RST;
      end else if (wr_en && paddr == SSOM_OFS_RANGE) begin
         range_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmode_r <= SSOM_CMODE_RST;
         width_r <= SSOM_WIDTH_RST;
      end else if (wr_en && paddr == SSOM_OFS_CCFG) begin
         cmode_r <= ssom_cmode_t'(pwdata[SSOM_CCFG_MODE_BIT]);
         width_r <= pwdata[SSOM_CCFG_WIDTH_LSB +: SSOM_WIDTH_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_r <= SSOM_IMASK_RST;
      end else if (wr_en && paddr == SSOM_OFS_IMASK) begin
         imask_r <= pwdata[SSOM_NEV-1:0];
      end
   end

   // ==========================================================
   // limit pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_sync1_r <= 1'b0;
         pos_sync2_r <= 1'b0;
         neg_sync1_r <= 1'b0;
         neg_sync2_r <= 1'b0;
      end else begin
         pos_sync1_r <= pos_limit_in;
         pos_sync2_r <= pos_sync1_r;
         neg_sync1_r <= neg_limit_in;
         neg_sync2_r <= neg_sync1_r;
      end
   end

   // ==========================================================
   // compare shaper
   ssom_compare_out u_compare (
      .pclk(pclk),
      .presetn(presetn),
      .compare_event(compare_event),
      .mode(cmode_r),
      .width(width_r),
      .level(compare_level)
   );

   // ==========================================================
   // status conditions
   assign err_abs = pos_error[31] ? (32'h0000_0000 - pos_error) : pos_error;

   always_comb begin
      // [RL1] alarm condition
      cond.alarm_out = drive_alarm;
      // [RL2] powered readiness
      cond.ready_out = servo_powered;
      // [RL3] within completion range
      cond.in_position_out = move_done && (err_abs <= {16'h0000, range_r});
      cond.brake_release_out = brake_release;
      // [RL4] zero-speed clamp
      cond.zero_speed_out = zero_clamp_active;
      // [RL5] servo enabled
      cond.servo_enabled_out = servo_enabled;
      // [RL6] limit echoes
      cond.pos_limit_echo_out = pos_sync2_r;
      cond.neg_limit_echo_out = neg_sync2_r;
      cond.compare_match_out = compare_level;
   end

   function automatic logic pick(input ssom_cond_t c, input ssom_fn_t f);
      logic v;
      v = 1'b0;
      unique case (f)
         FN_OFF: v = 1'b0;
         FN_ALARM: v = c.alarm_out;
         FN_READY: v = c.ready_out;
         FN_IN_POSITION: v = c.in_position_out;
         FN_BRAKE: v = c.brake_release_out;
         FN_ZERO_SPEED: v = c.zero_speed_out;
         FN_SERVO_ON: v = c.servo_enabled_out;
         FN_POS_LIMIT: v = c.pos_limit_echo_out;
         FN_NEG_LIMIT: v = c.neg_limit_echo_out;
         FN_COMPARE: v = c.compare_match_out;
         default: v = 1'b0;
      endcase
      return v;
   endfunction

   // ==========================================================
   // output pin mux
   generate
      for (genvar i = 0; i < SSOM_NPINS; i++) begin : g_pin
         // [RL10] per-pin selector
         // [RL9] shared functions allowed
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_r[i] <= 1'b0;
            end else begin
               pin_r[i] <= pick(cond, sel_r[i]);
            end
         end
      end
   endgenerate

   assign output_pin_1 = pin_r[0];
   assign output_pin_2 = pin_r[1];
   assign output_pin_3 = pin_r[2];

   // ==========================================================
   // interrupts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_d_r <= '0;
      end else begin
         cond_d_r <= cond;
      end
   end

   always_comb begin
      ev = 5'h00;
      ev[SSOM_EV_ALARM] = cond.alarm_out && !cond_d_r.alarm_out;
      ev[SSOM_EV_INPOS] = cond.in_position_out && !cond_d_r.in_position_out;
      ev[SSOM_EV_COMPARE] = compare_event;
      ev[SSOM_EV_POSLIM] = cond.pos_limit_echo_out && !cond_d_r.pos_limit_echo_out;
      ev[SSOM_EV_NEGLIM] = cond.neg_limit_echo_out && !cond_d_r.neg_limit_echo_out;
   end

   // set wins over a write-one clear in the same cycle
   always_comb begin
      istat_nxt = istat_r;
      if (wr_en && paddr == SSOM_OFS_ISTAT) begin
         istat_nxt = istat_r & ~pwdata[SSOM_NEV-1:0];
      end
      istat_nxt = istat_nxt | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= 5'h00;
         irq_r <= 1'b0;
      end else begin
         istat_r <= istat_nxt;
         irq_r <= |(istat_nxt & imask_r);
      end
   end

   assign irq = irq_r;

   // ==========================================================
   // checks
   logic sel_written_r;
   logic [1:0] up_cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_written_r <= 1'b0;
         up_cnt_r <= 2'h0;
      end else begin
         if (wr_en && paddr == SSOM_OFS_SEL) begin
            sel_written_r <= 1'b1;
         end
         if (up_cnt_r != 2'h3) begin
            up_cnt_r <= up_cnt_r + 2'h1;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_alarm_pin3: assert property ( // [RL1]
      !sel_written_r |=> output_pin_3 == $past(drive_alarm))
      else $error("alarm not on default pin 3");

   a_ready_pin2: assert property ( // [RL2]
      !sel_written_r |=> output_pin_2 == $past(servo_powered))
      else $error("ready not on default pin 2");

   a_inpos_range: assert property ( // [RL3]
      sel_r[0] == FN_IN_POSITION && move_done && err_abs > {16'h0000, range_r} |=> !output_pin_1)
      else $error("in-position asserted outside range");

   a_zero_speed: assert property ( // [RL4]
      sel_r[1] == FN_ZERO_SPEED |=> output_pin_2 == $past(zero_clamp_active))
      else $error("zero-speed output wrong");

   a_servo_on: assert property ( // [RL5]
      sel_r[2] == FN_SERVO_ON |=> output_pin_3 == $past(servo_enabled))
      else $error("servo-enabled output wrong");

   a_poslim_echo: assert property ( // [RL6]
      up_cnt_r == 2'h3 && sel_r[0] == FN_POS_LIMIT |=> output_pin_1 == $past(pos_limit_in, 3))
      else $error("positive limit echo wrong");

   a_neglim_echo: assert property ( // [RL6]
      up_cnt_r == 2'h3 && sel_r[1] == FN_NEG_LIMIT |=> output_pin_2 == $past(neg_limit_in, 3))
      else $error("negative limit echo wrong");

   a_brake_default: assert property ( // [RL8]
      !sel_written_r |=> output_pin_1 == $past(brake_release))
      else $error("brake not on default pin 1");

   a_shared_fn: assert property ( // [RL9]
      sel_r[0] == sel_r[1] |=> output_pin_1 == output_pin_2)
      else $error("shared function differs on pins");

   a_compare_pin: assert property ( // [RL7]
      sel_r[2] == FN_COMPARE |=> output_pin_3 == $past(compare_level))
      else $error("compare output not routed");

   a_irq_level: assert property (
      $rose(irq) |-> $past(|(istat_nxt & imask_r)))
      else $error("interrupt without masked status");

   c_alarm_pin: cover property (!sel_written_r && drive_alarm ##1 output_pin_3);
   c_shared: cover property (sel_r[0] == sel_r[2] && sel_r[0] != FN_OFF ##1 output_pin_1 && output_pin_3);
   c_pulse: cover property (cmode_r == CM_PULSE && compare_event ##1 compare_level [*2]);
   c_irq: cover property (irq);

endmodule

// ==== testbench/ssom_ctrl_model.sv ====
// master controller model: watches digital output pin 1 of the three output pins
// assumes pins are registered levels on pclk
module ssom_ctrl_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [2:0] pins, // observed output pins, pin 1 in bit 0
   output logic [15:0] width_1 // length of last high run on pin 1
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] run_r;

   // ==========================================================
   // pulse length measurement on pin 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 16'h0000;
         width_1 <= 16'h0000;
      end else if (pins[0]) begin
         run_r <= run_r + 16'h0001;
      end else begin
         if (run_r != 16'h0000) begin
            width_1 <= run_r;
         end
         run_r <= 16'h0000;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench of the servo status output mux
// assumes ssom_top with apb slave; the controller model watches the pins
module testbench
   import ssom_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, pos_error = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, irq, output_pin_1, output_pin_2, output_pin_3;
   logic drive_alarm = 1'b0, servo_powered = 1'b0, servo_enabled = 1'b0, move_done = 1'b0;
   logic zero_clamp_active = 1'b0, brake_release = 1'b0, pos_limit_in = 1'b0, neg_limit_in = 1'b0;
   logic compare_event = 1'b0;
   logic [15:0] width_1;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int n_tests = 0;

   always #2 pclk = ~pclk;

   ssom_top i_ssom_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .drive_alarm(drive_alarm), .servo_powered(servo_powered), .servo_enabled(servo_enabled),
      .move_done(move_done), .pos_error(pos_error), .zero_clamp_active(zero_clamp_active),
      .brake_release(brake_release), .pos_limit_in(pos_limit_in), .neg_limit_in(neg_limit_in),
      .compare_event(compare_event), .output_pin_1(output_pin_1), .output_pin_2(output_pin_2),
      .output_pin_3(output_pin_3), .irq(irq));

   ssom_ctrl_model i_ssom_ctrl_model (.pclk(pclk), .presetn(presetn),
      .pins({output_pin_3, output_pin_2, output_pin_1}), .width_1(width_1));

   // ==========================================================
   // shared tasks
   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_pins(input logic [2:0] exp);
      chk("pins", {29'h0, exp}, {29'h0, output_pin_3, output_pin_2, output_pin_1});
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // ready comes in the first access cycle
      chk("wait states", 32'h1, n);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h00000000);
      chk(what, exp, rd);
      chk("pslverr", {31'h0, e}, {31'h0, err});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // drives the condition behind a function code
   task automatic set_cond(input int code, input logic v);
      @(posedge pclk);
      case (code)
         1: drive_alarm <= v;
         2: servo_powered <= v;
         3: begin
            move_done <= 1'b1;
            pos_error <= v ? 32'h0000000A : 32'h0000000B;
         end
         4: brake_release <= v;
         5: zero_clamp_active <= v;
         6: servo_enabled <= v;
         7: pos_limit_in <= v;
         8: neg_limit_in <= v;
         9: compare_event <= 1'b1;
         default: ;
      endcase
      @(posedge pclk);
      compare_event <= 1'b0;
   endtask

   // ==========================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      finish_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk("sel", SSOM_OFS_SEL, 32'h00000124, 1'b0);
      rd_chk("range", SSOM_OFS_RANGE, 32'h0000000A, 1'b0);
      rd_chk("ccfg", SSOM_OFS_CCFG, 32'h00100000, 1'b0);
      rd_chk("imask", SSOM_OFS_IMASK, 32'h00000000, 1'b0);
      rd_chk("unmapped", 8'h1C, 32'h00000000, 1'b1);
      rd_chk("unaligned", 8'h02, 32'h00000000, 1'b1);
      set_cond(4, 1'b1);
      set_cond(2, 1'b1);
      set_cond(1, 1'b1);
      settle(2);
      chk_pins(3'b111);
      rd_chk("cond", SSOM_OFS_COND, 32'h0000000B, 1'b0);
      rd_chk("pins rd", SSOM_OFS_PINS, 32'h00000007, 1'b0);
      // codes above the last function drive nothing
      apb(1'b1, SSOM_OFS_SEL, 32'h00000FAB);
      settle(2);
      chk_pins(3'b000);
      apb(1'b1, SSOM_OFS_SEL, 32'h00000000);
      settle(2);
      chk_pins(3'b000);
      for (int c = 1; c <= 4; c++)
         set_cond(c, 1'b0);
      // every function on all three pins at once, set then cleared
      for (int c = 1; c <= 9; c++) begin
         apb(1'b1, SSOM_OFS_SEL, 32'h00000111 * c);
         set_cond(c, 1'b1);
         settle(4);
         chk_pins(3'b111);
         set_cond(c, 1'b0);
         settle(4);
         chk_pins(3'b000);
      end
      rd_chk("istat", SSOM_OFS_ISTAT, 32'h0000001F, 1'b0);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, SSOM_OFS_IMASK, 32'h00000001);
      settle(2);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, SSOM_OFS_ISTAT, 32'h0000001F);
      settle(2);
      chk("irq clear", 32'h0, {31'h0, irq});
      rd_chk("istat clr", SSOM_OFS_ISTAT, 32'h00000000, 1'b0);
      // pulse mode, programmed width 3 and width 0 acting as 1
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, SSOM_OFS_CCFG, (i == 0) ? 32'h00030001 : 32'h00000001);
         set_cond(9, 1'b1);
         settle(8);
         chk("pulse width", (i == 0) ? 32'h3 : 32'h1, {16'h0, width_1});
         chk_pins(3'b000);
      end
      finish_test();
   end
endmodule
